// ---- dv/ccs_link_assertions.sv ----
// concurrent checks on the two-wire link between host end and device end
`timescale 1ns/1ps
module ccs_link_assertions (
   // system
   input wire logic clk_sys,
   input wire logic srst,
   // resolved wires
   input wire logic scl,
   input wire logic sda,
   // open-drain drivers
   input wire logic sclHostOut,
   input wire logic sclHostOeN,
   input wire logic sdaDevOut,
   input wire logic sdaDevOeN
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);
   // bus conditions, sda moving while scl is high
   sequence s_start;
      scl && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $rose(sda);
   endsequence
   sequence s_dev_quiet;
      sdaDevOeN [*8];
   endsequence
   // drive values are tied low, so only the enables move the wires
   a_dev_drive_low: assert property (sdaDevOut == 1'b0)
      else $error("device sda drive value not low");
   a_host_clk_low: assert property (!sclHostOut && $fell(sclHostOeN) |-> !scl [*8])
      else $error("clock low phase too short");
   a_start_quiet: assert property (s_start |=> s_dev_quiet)
      else $error("device pulled sda right after start");
   a_stop_release: assert property (s_stop |=> s_dev_quiet)
      else $error("device pulled sda right after stop");
   a_ack_full_high: assert property ($rose(scl) && !sdaDevOeN |-> !sdaDevOeN [*8])
      else $error("device sda low not held through clock high");
   a_dev_pull_low: assert property ($fell(sdaDevOeN) |-> !scl && !$past(scl, 2))
      else $error("device pulled sda outside clock low");
   a_dev_rel_low: assert property ($rose(sdaDevOeN) |-> !scl && !$past(scl, 2))
      else $error("device released sda outside clock low");
   a_scl_high_len: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   cover property (s_start ##[1:1000] !sdaDevOeN);
endmodule : ccs_link_assertions

// ---- dv/test_converter_i2c_slave_port.sv ----
// self-checking bench: host end against device end, plus a bit-banged second link
`timescale 1ns/1ps
module test_converter_i2c_slave_port
   import ccs_pkg::*;
;
   localparam int BBQ = 20;
   localparam int LIM = 50000;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic uvlo = 1'b0;
   logic cmdValid = 1'b0;
   logic cmdRead = 1'b0;
   logic [7:0] cmdReg = 8'h00;
   logic [7:0] cmdData = 8'h00;
   logic cmdReady, doneStrobe, nackSeen, hs, hsB, wrStrobe, ackBit;
   logic [7:0] rdData, wrAddr, wrAddrB;
   logic [39:0] regs, regsB;
   logic [7:0] bad [3] = '{8'h00, 8'hE8, 8'hF0};
   int errors = 0;
   int cmpCount = 0;
   int nStrobe = 0;
   // main link joins both design ends, second link is driven by the bench
   ccs_link_if link();
   ccs_link_if linkB();
   ccs_dev_end ccs_dev_end_inst (.clk_sys(clk_sys), .srst(srst), .link(link.dev),
      .uvloActive(uvlo), .hsMode(hs), .regValues(regs), .wrStrobe(wrStrobe), .wrAddr(wrAddr));
   ccs_host_end ccs_host_end_inst (.clk_sys(clk_sys), .srst(srst), .link(link.host),
      .cmdValid(cmdValid), .cmdRead(cmdRead), .cmdReg(cmdReg), .cmdData(cmdData),
      .cmdReady(cmdReady), .doneStrobe(doneStrobe), .rdData(rdData), .nackSeen(nackSeen));
   ccs_dev_end ccs_dev_end_inst_b (.clk_sys(clk_sys), .srst(srst), .link(linkB.dev),
      .uvloActive(uvlo), .hsMode(hsB), .regValues(regsB), .wrStrobe(), .wrAddr(wrAddrB));
   ccs_link_assertions ccs_link_assertions_inst (.clk_sys(clk_sys), .srst(srst),
      .scl(link.scl), .sda(link.sda), .sclHostOut(link.sclHostOut),
      .sclHostOeN(link.sclHostOeN), .sdaDevOut(link.sdaDevOut), .sdaDevOeN(link.sdaDevOeN));
   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;
   // count applied writes, a write under lockout must not add one
   always @(posedge clk_sys)
   begin
      if (wrStrobe === 1'b1)
         nStrobe <= nStrobe + 1;
   end
   task stop_test;
      $display("errors=%0d compares=%0d", errors, cmpCount);
      if (errors == 0 && cmpCount > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task check(input logic [39:0] seen, input logic [39:0] exp);
      cmpCount++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : check
   // one host command; waits are bounded so a stuck sequencer ends the run
   task cmd(input logic rd, input logic [7:0] r, input logic [7:0] d);
      int n;
      n = 0;
      do begin @(negedge clk_sys); n++; end while (cmdReady !== 1'b1 && n < LIM);
      cmdRead = rd;
      cmdReg = r;
      cmdData = d;
      cmdValid = 1'b1;
      @(negedge clk_sys);
      cmdValid = 1'b0;
      do begin @(negedge clk_sys); n++; end while (doneStrobe !== 1'b1 && n < LIM);
      if (n >= LIM)
      begin
         errors++;
         stop_test();
      end
   endtask : cmd
   // bit-banged master on the second link, quarter of BBQ clocks
   task bb_wait;
      repeat (BBQ) @(negedge clk_sys);
   endtask : bb_wait
   task bb_start;
      linkB.sdaHostOeN = 1'b1;
      bb_wait();
      linkB.sclHostOeN = 1'b1;
      bb_wait();
      linkB.sdaHostOeN = 1'b0;
      bb_wait();
      linkB.sclHostOeN = 1'b0;
      bb_wait();
   endtask : bb_start
   task bb_stop;
      linkB.sdaHostOeN = 1'b0;
      bb_wait();
      linkB.sclHostOeN = 1'b1;
      bb_wait();
      linkB.sdaHostOeN = 1'b1;
      bb_wait();
   endtask : bb_stop
   // sda set only while scl is low, sampled mid high phase
   task bb_bit(input logic b, output logic s);
      linkB.sdaHostOeN = b;
      bb_wait();
      linkB.sclHostOeN = 1'b1;
      bb_wait();
      s = linkB.sda;
      bb_wait();
      linkB.sclHostOeN = 1'b0;
      bb_wait();
   endtask : bb_bit
   task bb_byte(input logic [7:0] d, output logic a);
      logic s;
      for (int i = 7; i >= 0; i--)
         bb_bit(d[i], s);
      bb_bit(1'b1, a);
   endtask : bb_byte
   // main sequence
   initial
   begin
      linkB.sclHostOut = 1'b0;
      linkB.sdaHostOut = 1'b0;
      linkB.sclHostOeN = 1'b0;
      linkB.sdaHostOeN = 1'b0;
      repeat (3) @(negedge clk_sys);
      srst = 1'b0;
      check(regs, CCS_REG_RESET);
      bb_stop();
      cmd(1'b0, 8'h03, 8'hA5);
      check(nackSeen, 1'b0);
      check(regs, 40'h00_00_A5_00_01);
      check(wrAddr, 8'h03);
      check(hs, 1'b0);
      cmd(1'b1, 8'h03, 8'h00);
      check(rdData, 8'hA5);
      cmd(1'b1, 8'h23, 8'h00);
      check(rdData, CCS_UNMAPPED_READ);
      check(nStrobe, 1);
      // lockout: port ignores the master, registers survive, high-speed mode drops
      bb_start();
      bb_byte(8'h08, ackBit);
      check(hsB, 1'b1);
      uvlo = 1'b1;
      repeat (10) @(negedge clk_sys);
      cmd(1'b0, 8'h03, 8'h5A);
      check(nackSeen, 1'b1);
      check(nStrobe, 1);
      check(hsB, 1'b0);
      uvlo = 1'b0;
      repeat (10) @(negedge clk_sys);
      cmd(1'b1, 8'h03, 8'h00);
      check(rdData, 8'hA5);
      // general call, foreign address and ten-bit prefix all left unanswered
      for (int i = 0; i < 3; i++)
      begin
         bb_start();
         bb_byte(bad[i], ackBit);
         bb_stop();
         check(ackBit, 1'b1);
      end
      bb_start();
      bb_byte(8'h08, ackBit);
      check(ackBit, 1'b1);
      check(hsB, 1'b1);
      bb_stop();
      check(hsB, 1'b0);
      // abort an address byte after three bits, then a full write
      bb_start();
      for (int i = 0; i < 3; i++)
         bb_bit(1'b1, ackBit);
      bb_start();
      bb_byte({CCS_SLAVE_ADDR, 1'b0}, ackBit);
      check(ackBit, 1'b0);
      bb_byte(8'h03, ackBit);
      check(ackBit, 1'b0);
      bb_byte(8'h3C, ackBit);
      check(ackBit, 1'b0);
      bb_stop();
      check(regsB[23:16], 8'h3C);
      check(wrAddrB, 8'h03);
      stop_test();
   end
endmodule : test_converter_i2c_slave_port

// ---- rtl/ccs_dev_end.sv ----
// device end of the serial control port: slave engine and register image
`timescale 1ns/1ps
// What this block does
// R1: port held idle while undervoltage lockout active
// R2: slave only, all four bus rates accepted
// R3: register values kept, no refresh needed
// R4: seven-bit addressing only, no general call
// R5: answers only address 1110101
// R6: host issues stop after power up
// R7: start is sda falling, scl high
// R8: sda changes only while scl low
// R9: matched address acked low in ninth clock
// R10: every byte followed by receiver acknowledge
// R11: stop is sda rising, releases bus
// R12: unimplemented register reads return 00h
// R13: host makes clock, address, start, stop
// R14: sda only pulled low or released
// R15: write applied at falling edge after ack
// R16: low direction bit writes, high reads
// R17: high-speed code not acked, mode until stop
// R18: register byte: five zero bits, three select
// R19: repeated start returns to address phase
// R20: sda released after own acknowledge slot
module ccs_dev_end
   import ccs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic srst,
   // link
   ccs_link_if.dev link,
   // converter side
   input wire logic uvloActive,
   output logic hsMode,
   output logic [39:0] regValues,
   output logic wrStrobe,
   output logic [7:0] wrAddr
);

   // true for the implemented register indices
   function automatic logic regHit(input logic [7:0] ptr);
      regHit = (ptr >= CCS_REG_FIRST) && (ptr < CCS_REG_FIRST + 8'(CCS_NUM_REGS));
   endfunction : regHit

   // byte returned for a read of ptr
   function automatic logic [7:0] readReg(input logic [39:0] regs, input logic [7:0] ptr);
      readReg = CCS_UNMAPPED_READ; // R12
      for (int i = 0; i < CCS_NUM_REGS; i++)
      begin
         if (regHit(ptr) && ptr == CCS_REG_FIRST + 8'(i))
         begin
            readReg = regs[8 * i +: 8];
         end
      end
   endfunction : readReg

   logic [1:0] sclSync_q;
   logic [1:0] sdaSync_q;
   logic [1:0] uvloSync_q;
   logic sclPrev_q;
   logic sdaPrev_q;
   logic sclS;
   logic sdaS;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;

   // pins cross into clk_sys through two flops before any decoding
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         sclSync_q <= 2'h3;
         sdaSync_q <= 2'h3;
         uvloSync_q <= 2'h3;
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end
      else
      begin
         sclSync_q <= {sclSync_q[0], link.scl}; // R2
         sdaSync_q <= {sdaSync_q[0], link.sda};
         uvloSync_q <= {uvloSync_q[0], uvloActive};
         sclPrev_q <= sclSync_q[1];
         sdaPrev_q <= sdaSync_q[1];
      end
   end

   // line events, start and stop only while scl stays high
   assign sclS = sclSync_q[1];
   assign sdaS = sdaSync_q[1];
   assign sclRise = sclS & ~sclPrev_q;
   assign sclFall = ~sclS & sclPrev_q;
   assign startEv = sclS & sclPrev_q & sdaPrev_q & ~sdaS; // R7
   assign stopEv = sclS & sclPrev_q & ~sdaPrev_q & sdaS; // R11

   ccs_dstate_t st_q, st_d, next_q, next_d;
   logic [3:0] bitCnt_q, bitCnt_d;
   logic [7:0] shift_q, shift_d;
   logic [7:0] ptr_q, ptr_d;
   logic [39:0] regs_q, regs_d;
   logic sdaDrv_q, sdaDrv_d;
   logic wrPend_q, wrPend_d;
   logic hs_q, hs_d;
   logic mAck_q, mAck_d;
   logic wrStrobe_q, wrStrobe_d;
   logic [7:0] wrAddr_q, wrAddr_d;

   // slave engine: samples on scl rise, changes sda only after scl fall or when lockout releases it
   always_comb
   begin
      st_d = st_q;
      next_d = next_q;
      bitCnt_d = bitCnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      regs_d = regs_q;
      sdaDrv_d = sdaDrv_q;
      wrPend_d = wrPend_q;
      hs_d = hs_q;
      mAck_d = mAck_q;
      wrStrobe_d = 1'b0;
      wrAddr_d = wrAddr_q;
      if (uvloSync_q[1])
      begin
         // lockout drops any transfer; register image is untouched
         st_d = D_IDLE; // R1
         sdaDrv_d = 1'b0;
         wrPend_d = 1'b0;
         hs_d = 1'b0;
      end
      else if (stopEv)
      begin
         st_d = D_IDLE; // R11
         sdaDrv_d = 1'b0;
         wrPend_d = 1'b0;
         hs_d = 1'b0; // R17
      end
      else if (startEv)
      begin
         // a repeated start aborts whatever byte was in flight
         st_d = D_ADDR; // R19
         bitCnt_d = 4'h0;
         sdaDrv_d = 1'b0;
         wrPend_d = 1'b0;
      end
      else
      begin
         case (st_q)
            D_ADDR, D_REG, D_WDATA:
            begin
               if (sclRise && bitCnt_q < CCS_BYTE_BITS)
               begin
                  shift_d = {shift_q[6:0], sdaS}; // R8
                  bitCnt_d = bitCnt_q + 4'h1;
               end
               else if (sclFall && bitCnt_q == CCS_BYTE_BITS)
               begin
                  bitCnt_d = 4'h0;
                  st_d = D_ACK;
                  sdaDrv_d = 1'b1; // R10
                  if (st_q == D_ADDR)
                  begin
                     if (shift_q[7:1] == CCS_SLAVE_ADDR) // R4 R5
                     begin
                        next_d = shift_q[0] ? D_RDATA : D_REG; // R16 R9
                     end
                     else
                     begin
                        // no ack; a high-speed code only switches the mode
                        sdaDrv_d = 1'b0; // R9
                        st_d = D_IDLE;
                        if (shift_q[7:3] == CCS_HS_CODE_TOP)
                        begin
                           hs_d = 1'b1; // R17
                        end
                     end
                  end
                  else if (st_q == D_REG)
                  begin
                     // nonzero top bits point past the map, so they act as unmapped
                     ptr_d = (shift_q[7:3] == CCS_REG_TOP_ZERO) ? shift_q : 8'hFF; // R18
                     next_d = D_WDATA;
                  end
                  else
                  begin
                     wrPend_d = 1'b1;
                     next_d = D_WDATA;
                  end
               end
            end
            D_ACK:
            begin
               if (sclFall)
               begin
                  sdaDrv_d = 1'b0; // R20
                  st_d = next_q;
                  if (wrPend_q)
                  begin
                     wrPend_d = 1'b0;
                     wrStrobe_d = 1'b1;
                     wrAddr_d = ptr_q;
                     for (int i = 0; i < CCS_NUM_REGS; i++)
                     begin
                        if (regHit(ptr_q) && ptr_q == CCS_REG_FIRST + 8'(i))
                        begin
                           regs_d[8 * i +: 8] = shift_q; // R15
                        end
                     end
                  end
                  if (next_q == D_RDATA)
                  begin
                     shift_d = readReg(regs_q, ptr_q);
                     sdaDrv_d = ~shift_d[7]; // R20
                     bitCnt_d = 4'h0;
                  end
               end
            end
            D_RDATA:
            begin
               if (sclRise)
               begin
                  bitCnt_d = bitCnt_q + 4'h1;
               end
               else if (sclFall)
               begin
                  if (bitCnt_q == CCS_BYTE_BITS)
                  begin
                     sdaDrv_d = 1'b0; // R10
                     st_d = D_MACK;
                  end
                  else
                  begin
                     shift_d = {shift_q[6:0], 1'b0};
                     sdaDrv_d = ~shift_q[6]; // R14
                  end
               end
            end
            D_MACK:
            begin
               if (sclRise)
               begin
                  mAck_d = ~sdaS;
               end
               else if (sclFall)
               begin
                  if (mAck_q)
                  begin
                     st_d = D_RDATA;
                     shift_d = readReg(regs_q, ptr_q);
                     sdaDrv_d = ~shift_d[7];
                     bitCnt_d = 4'h0;
                  end
                  else
                  begin
                     st_d = D_IDLE;
                  end
               end
            end
            default:
            begin
               st_d = D_IDLE;
               sdaDrv_d = 1'b0;
            end
         endcase
      end
   end

   // register the engine; the register image is only reset by srst
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_q <= D_IDLE;
         next_q <= D_IDLE;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         ptr_q <= 8'h00;
         regs_q <= CCS_REG_RESET;
         sdaDrv_q <= 1'b0;
         wrPend_q <= 1'b0;
         hs_q <= 1'b0;
         mAck_q <= 1'b0;
         wrStrobe_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end
      else
      begin
         st_q <= st_d;
         next_q <= next_d;
         bitCnt_q <= bitCnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         regs_q <= regs_d; // R3
         sdaDrv_q <= sdaDrv_d;
         wrPend_q <= wrPend_d;
         hs_q <= hs_d;
         mAck_q <= mAck_d;
         wrStrobe_q <= wrStrobe_d;
         wrAddr_q <= wrAddr_d;
      end
   end

   // open drain: value stays low, the enable decides
   assign link.sdaDevOut = 1'b0; // R14
   assign link.sdaDevOeN = ~sdaDrv_q; // R14
   assign hsMode = hs_q;
   assign regValues = regs_q;
   assign wrStrobe = wrStrobe_q;
   assign wrAddr = wrAddr_q;

endmodule : ccs_dev_end

// ---- rtl/ccs_host_end.sv ----
// host end: bus master issuing single register writes and reads
`timescale 1ns/1ps
module ccs_host_end
   import ccs_pkg::*;
(
   // system
   input wire logic clk_sys,
   input wire logic srst,
   // link
   ccs_link_if.host link,
   // command port
   input wire logic cmdValid,
   input wire logic cmdRead,
   input wire logic [7:0] cmdReg,
   input wire logic [7:0] cmdData,
   output logic cmdReady,
   output logic doneStrobe,
   output logic [7:0] rdData,
   output logic nackSeen
);

   // kind of each step of a write or read sequence
   function automatic ccs_kind_t stepKind(input logic rd, input logic [2:0] step);
      case (step)
         3'h0: stepKind = K_START; // R7 R13
         3'h3: stepKind = rd ? K_START : K_TX;
         3'h5: stepKind = K_RX;
         3'h1, 3'h2: stepKind = K_TX;
         3'h4: stepKind = rd ? K_TX : K_STOP;
         default: stepKind = K_STOP; // R11
      endcase
   endfunction : stepKind

   // byte sent in a transmit step
   function automatic logic [7:0] stepByte(input logic rd, input logic [2:0] step,
      input logic [7:0] regA, input logic [7:0] dat);
      case (step)
         3'h1: stepByte = {CCS_SLAVE_ADDR, 1'b0}; // R16
         3'h2: stepByte = regA; // R18
         3'h4: stepByte = {CCS_SLAVE_ADDR, 1'b1}; // R16
         default: stepByte = rd ? 8'h00 : dat;
      endcase
   endfunction : stepByte

   logic [1:0] sdaSync_q;
   // link sda crosses in through two flops
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         sdaSync_q <= 2'h3;
      end
      else
      begin
         sdaSync_q <= {sdaSync_q[0], link.sda};
      end
   end

   ccs_hstate_t st_q, st_d;
   logic [7:0] div_q, div_d;
   logic [1:0] qtr_q, qtr_d;
   logic [3:0] bit_q, bit_d;
   logic [2:0] step_q, step_d;
   logic rd_q, rd_d;
   logic [7:0] reg_q, reg_d;
   logic [7:0] dat_q, dat_d;
   logic [7:0] rx_q, rx_d;
   logic sclOeN_q, sclOeN_d;
   logic sdaOeN_q, sdaOeN_d;
   logic nack_q, nack_d;
   logic done_q, done_d;
   logic [7:0] rdData_q, rdData_d;
   logic tick;
   ccs_kind_t kind;
   logic [7:0] txByte;

   // quarter-bit enable from the divider; scl is only ever changed on it
   assign tick = (div_q == CCS_QUARTER_LAST);
   assign kind = (st_q == H_INIT) ? K_STOP : stepKind(rd_q, step_q);
   assign txByte = stepByte(rd_q, step_q, reg_q, dat_q);

   // master sequencer: quarter 0 sets sda, 1 raises scl, 2 samples or makes the start/stop edge, 3 drops scl except in a stop
   always_comb
   begin
      st_d = st_q;
      div_d = tick ? 8'h00 : div_q + 8'h01;
      qtr_d = qtr_q;
      bit_d = bit_q;
      step_d = step_q;
      rd_d = rd_q;
      reg_d = reg_q;
      dat_d = dat_q;
      rx_d = rx_q;
      sclOeN_d = sclOeN_q;
      sdaOeN_d = sdaOeN_q;
      nack_d = nack_q;
      done_d = 1'b0;
      rdData_d = rdData_q;
      if (st_q == H_IDLE)
      begin
         div_d = 8'h00;
         if (cmdValid)
         begin
            st_d = H_RUN;
            rd_d = cmdRead;
            reg_d = cmdReg;
            dat_d = cmdData;
            step_d = 3'h0;
            qtr_d = 2'h0;
            bit_d = 4'h0;
            nack_d = 1'b0;
         end
      end
      else if (tick)
      begin
         qtr_d = qtr_q + 2'h1;
         case (qtr_q)
            2'h0:
            begin
               // sda moves only with scl low
               case (kind)
                  K_START: sdaOeN_d = 1'b1;
                  K_STOP: sdaOeN_d = 1'b0;
                  K_TX: sdaOeN_d = (bit_q < CCS_BYTE_BITS) ? txByte[3'(4'h7 - bit_q)] : 1'b1;
                  default: sdaOeN_d = 1'b1; // a single read ends with no ack
               endcase
            end
            2'h1: sclOeN_d = 1'b1;
            2'h2:
            begin
               case (kind)
                  K_START: sdaOeN_d = 1'b0; // R7
                  K_STOP: sdaOeN_d = 1'b1; // R11
                  K_TX: nack_d = nack_q | (bit_q == CCS_BYTE_BITS && sdaSync_q[1]); // R10
                  default:
                  begin
                     if (bit_q < CCS_BYTE_BITS)
                     begin
                        rx_d = {rx_q[6:0], sdaSync_q[1]};
                     end
                  end
               endcase
            end
            default:
            begin
               if (kind == K_STOP)
               begin
                  st_d = H_IDLE;
                  done_d = (st_q == H_RUN);
                  rdData_d = rx_q;
               end
               else
               begin
                  sclOeN_d = 1'b0; // R13
                  if (kind == K_START || bit_q == CCS_BYTE_BITS)
                  begin
                     bit_d = 4'h0;
                     // a refused byte skips straight to the stop
                     if (nack_d)
                     begin
                        step_d = rd_q ? CCS_STOP_STEP_RD : CCS_STOP_STEP_WR;
                     end
                     else
                     begin
                        step_d = step_q + 3'h1;
                     end
                  end
                  else
                  begin
                     bit_d = bit_q + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // register the sequencer; after reset a lone stop clears the slave engine
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         st_q <= H_INIT; // R6
         div_q <= 8'h00;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         step_q <= 3'h0;
         rd_q <= 1'b0;
         reg_q <= 8'h00;
         dat_q <= 8'h00;
         rx_q <= 8'h00;
         sclOeN_q <= 1'b0;
         sdaOeN_q <= 1'b0;
         nack_q <= 1'b0;
         done_q <= 1'b0;
         rdData_q <= 8'h00;
      end
      else
      begin
         st_q <= st_d;
         div_q <= div_d;
         qtr_q <= qtr_d;
         bit_q <= bit_d;
         step_q <= step_d;
         rd_q <= rd_d;
         reg_q <= reg_d;
         dat_q <= dat_d;
         rx_q <= rx_d;
         sclOeN_q <= sclOeN_d;
         sdaOeN_q <= sdaOeN_d;
         nack_q <= nack_d;
         done_q <= done_d;
         rdData_q <= rdData_d;
      end
   end

   assign link.sclHostOut = 1'b0;
   assign link.sclHostOeN = sclOeN_q;
   assign link.sdaHostOut = 1'b0;
   assign link.sdaHostOeN = sdaOeN_q;
   assign cmdReady = (st_q == H_IDLE);
   assign doneStrobe = done_q;
   assign rdData = rdData_q;
   assign nackSeen = nack_q;

endmodule : ccs_host_end

// ---- rtl/ccs_link_if.sv ----
// two-wire open-drain link joining host end and device end
`timescale 1ns/1ps
interface ccs_link_if;
   // open-drain drivers, enable low while the line is pulled down
   logic sclHostOut;
   logic sclHostOeN;
   logic sdaHostOut;
   logic sdaHostOeN;
   logic sdaDevOut;
   logic sdaDevOeN;
   // resolved wire levels, pull-ups make an undriven line high
   logic scl;
   logic sda;
   assign scl = sclHostOeN | sclHostOut;
   assign sda = (sdaHostOeN | sdaHostOut) & (sdaDevOeN | sdaDevOut);
   modport dev (input scl, input sda, output sdaDevOut, output sdaDevOeN);
   modport host (input scl, input sda, output sclHostOut, output sclHostOeN,
      output sdaHostOut, output sdaHostOeN);
endinterface : ccs_link_if

// ---- rtl/ccs_pkg.sv ----
// shared constants and types for the converter serial control port, both ends
package ccs_pkg;
   // link addressing
   localparam logic [6:0] CCS_SLAVE_ADDR = 7'h75;
   localparam logic [4:0] CCS_HS_CODE_TOP = 5'h01;
   localparam logic [4:0] CCS_REG_TOP_ZERO = 5'h00;
   localparam logic [3:0] CCS_BYTE_BITS = 4'h8;
   // register window: indices 1..5 are implemented, anything else reads as zero
   localparam int CCS_NUM_REGS = 5;
   localparam logic [7:0] CCS_REG_FIRST = 8'h01;
   localparam logic [7:0] CCS_UNMAPPED_READ = 8'h00;
   // reset image, register 1 in the low byte
   localparam logic [39:0] CCS_REG_RESET = 40'h00_00_00_00_01;
   // timing of the host end
   localparam int CCS_CLK_KHZ = 200000;
   localparam int CCS_SCL_KHZ = 400;
   localparam int CCS_QUARTER_CYC = CCS_CLK_KHZ / (4 * CCS_SCL_KHZ);
   localparam logic [7:0] CCS_QUARTER_LAST = 8'(CCS_QUARTER_CYC - 1);
   // host sequence positions of the closing stop
   localparam logic [2:0] CCS_STOP_STEP_WR = 3'h4;
   localparam logic [2:0] CCS_STOP_STEP_RD = 3'h6;
   // device end states
   typedef enum logic [2:0] {
      D_IDLE = 3'b000,
      D_ADDR = 3'b001,
      D_REG = 3'b010,
      D_WDATA = 3'b011,
      D_ACK = 3'b100,
      D_RDATA = 3'b101,
      D_MACK = 3'b110
   } ccs_dstate_t;
   // host end states
   typedef enum logic [1:0] {
      H_INIT = 2'b00,
      H_IDLE = 2'b01,
      H_RUN = 2'b10
   } ccs_hstate_t;
   // kinds of host sequence steps
   typedef enum logic [1:0] {
      K_START = 2'b00,
      K_TX = 2'b01,
      K_RX = 2'b10,
      K_STOP = 2'b11
   } ccs_kind_t;
endpackage : ccs_pkg
